//--- hw/adc_flag_pkg.sv
// package: register map, field layout and carriers for the converter status-flag block
package adc_flag_pkg;

   // -------------------------------------------------------------------
   // sizes
   // -------------------------------------------------------------------
   localparam int unsigned NUM_CH   = 8;
   localparam int unsigned CH_W     = 3;
   localparam int unsigned RES_W    = 10;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;

   // -------------------------------------------------------------------
   // register byte offsets
   // -------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;  // write: start pulse
   localparam logic [ADDR_W-1:0] OFS_MODE     = 8'h04;  // sleep option
   localparam logic [ADDR_W-1:0] OFS_CH_EN    = 8'h10;  // write ones to enable
   localparam logic [ADDR_W-1:0] OFS_CH_DIS   = 8'h14;  // write ones to disable
   localparam logic [ADDR_W-1:0] OFS_CH_STAT  = 8'h18;  // enabled channels
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h1C;  // flags, read clears overruns
   localparam logic [ADDR_W-1:0] OFS_LAST     = 8'h20;  // last_result_reg
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h24;  // sticky events, write one clears
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h28;  // event mask, same layout
   localparam logic [ADDR_W-1:0] OFS_RES_BASE = 8'h30;  // channel_result_reg 0..7
   localparam logic [ADDR_W-1:0] OFS_RES_TOP  = 8'h4C;

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int unsigned CTRL_START_BIT = 1;
   localparam int unsigned MODE_SLEEP_BIT = 5;
   localparam int unsigned ST_DONE_LSB    = 0;
   localparam int unsigned ST_OVR_LSB     = 8;
   localparam int unsigned ST_DATA_READY_FLAG_BIT    = 16;
   localparam int unsigned ST_GOVR_BIT    = 17;
   localparam int unsigned LAST_CH_LSB    = 12;
   localparam int unsigned EVT_W          = 2;
   localparam int unsigned EVT_STORE_BIT  = 0;
   localparam int unsigned EVT_GOVR_BIT   = 1;

   // -------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------
   localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;
   localparam logic [NUM_CH-1:0] CH_EN_RST  = 8'h00;
   localparam logic [EVT_W-1:0]  EVT_RST    = 2'h0;
   localparam logic [RES_W-1:0]  RES_RST    = 10'h000;
   localparam logic [CH_W-1:0]   CH_RST     = 3'h0;

   // -------------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------------
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic             valid;  // one-cycle end of conversion
      logic [CH_W-1:0]  ch;
      logic [RES_W-1:0] data;
   } conv_end_s;

endpackage

//--- hw/adc_status_flags.sv
// converter status flags, result registers and apb register file
`timescale 1ns/1ps
module adc_status_flags (
   input  wire logic                          CORE_CLK_IN,
   input  wire logic                          RESET_N_IN,
   input  wire adc_flag_pkg::apb_req_s        APB_REQ_IN,
   input  wire adc_flag_pkg::conv_end_s       CONV_END_IN,
   output logic [adc_flag_pkg::DATA_W-1:0]    PRDATA_OUT,
   output logic                               PREADY_OUT,
   output logic                               PSLVERR_OUT,
   output logic [adc_flag_pkg::NUM_CH-1:0]    CH_EN_OUT,
   output logic                               START_OUT,
   output logic                               SLEEP_OUT,
   output logic                               IRQ_OUT
);
   import adc_flag_pkg::*;

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   logic [NUM_CH-1:0] ch_en_q;
   logic [NUM_CH-1:0] done_q;
   logic [NUM_CH-1:0] done_d;
   logic [NUM_CH-1:0] ovr_q;
   logic [NUM_CH-1:0] ovr_d;
   logic              data_ready_flag_q;
   logic              data_ready_flag_d;
   logic              global_overrun_flag_q;
   logic              global_overrun_flag_d;
   logic [RES_W-1:0]  result_q [NUM_CH];
   logic [RES_W-1:0]  last_data_q;
   logic [CH_W-1:0]   last_ch_q;
   logic              sleep_q;
   logic              start_q;
   logic [EVT_W-1:0]  evt_q;
   logic [EVT_W-1:0]  evt_d;
   logic [EVT_W-1:0]  mask_q;
   logic              irq_q;
   logic [DATA_W-1:0] prdata_q;
   logic              pready_q;
   logic              pslverr_q;

   // -------------------------------------------------------------------
   // apb decode
   // -------------------------------------------------------------------
   // every side effect happens at the edge that closes the setup cycle, the
   // same edge that samples read data, so a flag can never be read and then
   // cleared with an event slipping in between the two
   logic              acc;
   logic              rd;
   logic              wr;
   logic              sel_ctrl;
   logic              sel_mode;
   logic              sel_en;
   logic              sel_dis;
   logic              sel_chst;
   logic              sel_stat;
   logic              sel_last;
   logic              sel_istat;
   logic              sel_imask;
   logic              sel_res;
   logic              mapped;
   logic [CH_W-1:0]   res_idx;
   logic [ADDR_W-1:0] res_ofs;

   assign acc       = APB_REQ_IN.psel & ~APB_REQ_IN.penable;
   assign rd        = acc & ~APB_REQ_IN.pwrite;
   assign wr        = acc & APB_REQ_IN.pwrite;
   assign sel_ctrl  = APB_REQ_IN.paddr == OFS_CTRL;
   assign sel_mode  = APB_REQ_IN.paddr == OFS_MODE;
   assign sel_en    = APB_REQ_IN.paddr == OFS_CH_EN;
   assign sel_dis   = APB_REQ_IN.paddr == OFS_CH_DIS;
   assign sel_chst  = APB_REQ_IN.paddr == OFS_CH_STAT;
   assign sel_stat  = APB_REQ_IN.paddr == OFS_STATUS;
   assign sel_last  = APB_REQ_IN.paddr == OFS_LAST;
   assign sel_istat = APB_REQ_IN.paddr == OFS_IRQ_STAT;
   assign sel_imask = APB_REQ_IN.paddr == OFS_IRQ_MASK;
   assign res_ofs   = APB_REQ_IN.paddr - OFS_RES_BASE;
   assign sel_res   = (APB_REQ_IN.paddr >= OFS_RES_BASE) && (APB_REQ_IN.paddr <= OFS_RES_TOP)
                      && (APB_REQ_IN.paddr[1:0] == 2'h0);
   assign res_idx   = res_ofs[CH_W+1:2];
   assign mapped    = sel_ctrl | sel_mode | sel_en | sel_dis | sel_chst | sel_stat
                      | sel_last | sel_istat | sel_imask | sel_res;

   // read strobes that act on the flags
   logic rd_stat;
   logic rd_last;
   logic rd_res;
   assign rd_stat = rd & sel_stat;
   assign rd_last = rd & sel_last;
   assign rd_res  = rd & sel_res;

   // -------------------------------------------------------------------
   // conversion end
   // -------------------------------------------------------------------
   // a result is kept only for a channel enabled before this edge; a disable
   // write in the same cycle is seen one edge later and so does not cancel it
   // limitation: a dropped result leaves no trace at all, so software cannot
   // tell it from a conversion that never ran
   logic store;
   assign store = CONV_END_IN.valid & ch_en_q[CONV_END_IN.ch];

   // -------------------------------------------------------------------
   // per-channel done and overrun flags
   // -------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         logic hit;
         logic clr_done;
         assign hit      = store && (CONV_END_IN.ch == CH_W'(gi));
         // only the addressed channel, or the last-result owner, is cleared
         assign clr_done = (rd_res && (res_idx == CH_W'(gi)))
                           | (rd_last && (last_ch_q == CH_W'(gi)));
         assign done_d[gi] = hit | (done_q[gi] & ~clr_done);
         // overrun needs a pending unread result; a plain done set during a
         // status read does not protect the old overrun from clearing
         assign ovr_d[gi]  = (hit & done_q[gi]) | (ovr_q[gi] & ~rd_stat);

         always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
            if (!RESET_N_IN) begin
               result_q[gi] <= RES_RST;
            end else if (hit) begin
               result_q[gi] <= CONV_END_IN.data;
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // global flags
   // -------------------------------------------------------------------
   // data-ready is tied to the stored result only; channel result reads do
   // not touch it, so mixed polling of both styles stays consistent
   assign data_ready_flag_d     = store | (data_ready_flag_q & ~rd_last);
   // a fresh overrun wins over a status read in the same cycle, so no overrun
   // can slip in between the read that reports and the read that clears
   assign global_overrun_flag_d = (store & data_ready_flag_q)
                                  | (global_overrun_flag_q & ~rd_stat);

   // -------------------------------------------------------------------
   // interrupt events
   // -------------------------------------------------------------------
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   assign evt_set[EVT_STORE_BIT] = store;
   assign evt_set[EVT_GOVR_BIT]  = store & data_ready_flag_q;
   assign evt_clr = (wr & sel_istat) ? APB_REQ_IN.pwdata[EVT_W-1:0] : EVT_RST;
   assign evt_d   = evt_set | (evt_q & ~evt_clr);

   // built from the next event state so the line rises with the status bit;
   // a mask write only takes hold one cycle later
   logic irq_d;
   assign irq_d = |(evt_d & mask_q);

   // -------------------------------------------------------------------
   // read data mux
   // -------------------------------------------------------------------
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] last_word;
   logic [DATA_W-1:0] rdata;
   always_comb begin
      status_word = DATA_ZERO;
      status_word[ST_DONE_LSB +: NUM_CH] = done_q;
      status_word[ST_OVR_LSB +: NUM_CH]  = ovr_q;
      status_word[ST_DATA_READY_FLAG_BIT]           = data_ready_flag_q;
      status_word[ST_GOVR_BIT]           = global_overrun_flag_q;
   end

   always_comb begin
      last_word = DATA_ZERO;
      last_word[RES_W-1:0]              = last_data_q;
      last_word[LAST_CH_LSB +: CH_W]    = last_ch_q;
   end

   // unmapped and write-only offsets read as zero
   always_comb begin
      rdata = DATA_ZERO;
      if (sel_mode) begin
         rdata[MODE_SLEEP_BIT] = sleep_q;
      end else if (sel_chst) begin
         rdata[NUM_CH-1:0] = ch_en_q;
      end else if (sel_stat) begin
         rdata = status_word;
      end else if (sel_last) begin
         rdata = last_word;
      end else if (sel_istat) begin
         rdata[EVT_W-1:0] = evt_q;
      end else if (sel_imask) begin
         rdata[EVT_W-1:0] = mask_q;
      end else if (sel_res) begin
         rdata[RES_W-1:0] = result_q[res_idx];
      end
   end

   // -------------------------------------------------------------------
   // flag registers
   // -------------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         done_q                <= CH_EN_RST;
         ovr_q                 <= CH_EN_RST;
         data_ready_flag_q     <= 1'b0;
         global_overrun_flag_q <= 1'b0;
         evt_q                 <= EVT_RST;
      end else begin
         done_q                <= done_d;
         ovr_q                 <= ovr_d;
         data_ready_flag_q     <= data_ready_flag_d;
         global_overrun_flag_q <= global_overrun_flag_d;
         evt_q                 <= evt_d;
      end
   end

   // last-result register follows every stored result; the channel number
   // travels with the data so a last-result read clears the done flag of the
   // channel it actually returned
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         last_data_q <= RES_RST;
         last_ch_q   <= CH_RST;
      end else if (store) begin
         last_data_q <= CONV_END_IN.data;
         last_ch_q   <= CONV_END_IN.ch;
      end
   end

   // -------------------------------------------------------------------
   // control registers
   // -------------------------------------------------------------------
   // start is a one-cycle pulse; sleep is only a level handed to the
   // converter, which applies it after the conversion that start begins
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ch_en_q <= CH_EN_RST;
         sleep_q <= 1'b0;
         start_q <= 1'b0;
         mask_q  <= EVT_RST;
      end else begin
         start_q <= wr & sel_ctrl & APB_REQ_IN.pwdata[CTRL_START_BIT];
         if (wr && sel_mode) begin
            sleep_q <= APB_REQ_IN.pwdata[MODE_SLEEP_BIT];
         end
         if (wr && sel_en) begin
            ch_en_q <= ch_en_q | APB_REQ_IN.pwdata[NUM_CH-1:0];
         end else if (wr && sel_dis) begin
            ch_en_q <= ch_en_q & ~APB_REQ_IN.pwdata[NUM_CH-1:0];
         end
         if (wr && sel_imask) begin
            mask_q <= APB_REQ_IN.pwdata[EVT_W-1:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // apb answer and interrupt
   // -------------------------------------------------------------------
   // one fixed wait-free access phase: ready rises in the first access cycle;
   // a master that drops psel after setup still gets the side effects, which
   // a conforming master never does
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         prdata_q  <= DATA_ZERO;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q     <= 1'b0;
      end else begin
         pready_q  <= acc;
         pslverr_q <= acc & ~mapped;
         irq_q     <= irq_d;
         if (rd) begin
            prdata_q <= rdata;
         end
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign PRDATA_OUT  = prdata_q;
   assign PREADY_OUT  = pready_q;
   assign PSLVERR_OUT = pslverr_q;
   assign CH_EN_OUT   = ch_en_q;
   assign START_OUT   = start_q;
   assign SLEEP_OUT   = sleep_q;
   assign IRQ_OUT     = irq_q;

endmodule // adc_status_flags

//--- verification/adc_flag_monitor.sv
// checker of bus timing and control outputs of the converter status-flag block
`timescale 1ns/1ps
module adc_flag_monitor
   import adc_flag_pkg::*;
(
   input wire logic                              CORE_CLK_IN,
   input wire logic                              RESET_N_IN,
   input wire adc_flag_pkg::apb_req_s            APB_REQ_IN,
   input wire adc_flag_pkg::conv_end_s           CONV_END_IN,
   input wire logic [adc_flag_pkg::DATA_W-1:0]   PRDATA_OUT,
   input wire logic                              PREADY_OUT,
   input wire logic                              PSLVERR_OUT,
   input wire logic [adc_flag_pkg::NUM_CH-1:0]   CH_EN_OUT,
   input wire logic                              START_OUT,
   input wire logic                              SLEEP_OUT,
   input wire logic                              IRQ_OUT
);
   // -------------------------------------------------------------------
   // decode of the request as the slave sees it
   // -------------------------------------------------------------------
   wire logic [ADDR_W-1:0] pa    = APB_REQ_IN.paddr;
   wire logic [DATA_W-1:0] pd    = APB_REQ_IN.pwdata;
   wire logic              setup = APB_REQ_IN.psel && !APB_REQ_IN.penable;
   wire logic              wr    = setup && APB_REQ_IN.pwrite;
   wire logic              rsv   = !(pa inside {OFS_CTRL, OFS_MODE, OFS_CH_EN, OFS_CH_DIS, OFS_CH_STAT,
      OFS_STATUS, OFS_LAST, OFS_IRQ_STAT, OFS_IRQ_MASK} || (pa >= OFS_RES_BASE && pa <= OFS_RES_TOP && pa[1:0] == 2'h0));

   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   // -------------------------------------------------------------------
   // sequences and assertions
   // -------------------------------------------------------------------
   sequence setup_s; setup; endsequence
   sequence answer_s; PREADY_OUT ##1 !PREADY_OUT; endsequence
   sequence start_s; START_OUT ##1 !START_OUT; endsequence

   pready_answer_a: assert property (setup_s |=> answer_s) else $error("ready missing after setup");
   pready_cause_a: assert property (PREADY_OUT |-> $past(setup)) else $error("ready without setup");
   slverr_rsv_a: assert property (setup && rsv |=> PSLVERR_OUT && PREADY_OUT) else $error("no error on hole");
   slverr_map_a: assert property (setup && !rsv |=> !PSLVERR_OUT) else $error("error on mapped register");
   rsv_zero_a: assert property (setup && rsv && !APB_REQ_IN.pwrite |=> PRDATA_OUT == DATA_ZERO)
      else $error("hole reads nonzero");
   start_pulse_a: assert property (wr && pa == OFS_CTRL && pd[CTRL_START_BIT] |=> start_s)
      else $error("start pulse wrong");
   sleep_mode_a: assert property (wr && pa == OFS_MODE |=> SLEEP_OUT == $past(pd[MODE_SLEEP_BIT]))
      else $error("sleep option not taken");
   chan_set_a: assert property (wr && pa == OFS_CH_EN |=> (CH_EN_OUT & $past(pd[NUM_CH-1:0])) == $past(pd[NUM_CH-1:0]))
      else $error("channel not enabled");
   chan_clr_a: assert property (wr && pa == OFS_CH_DIS |=> (CH_EN_OUT & $past(pd[NUM_CH-1:0])) == CH_EN_RST)
      else $error("channel not disabled");
   // a store raises the line at its own edge, a mask write only one edge later
   irq_cause_a: assert property ($rose(IRQ_OUT) |-> $past(CONV_END_IN.valid) || $past(wr && pa == OFS_IRQ_MASK, 2))
      else $error("interrupt without cause");
endmodule // adc_flag_monitor

bind adc_status_flags adc_flag_monitor mon (.CORE_CLK_IN(CORE_CLK_IN), .RESET_N_IN(RESET_N_IN),
   .APB_REQ_IN(APB_REQ_IN), .CONV_END_IN(CONV_END_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
   .PSLVERR_OUT(PSLVERR_OUT), .CH_EN_OUT(CH_EN_OUT), .START_OUT(START_OUT), .SLEEP_OUT(SLEEP_OUT), .IRQ_OUT(IRQ_OUT));

//--- verification/adc_status_flags_test.sv
// self-checking bench of the converter status-flag block
`timescale 1ns/1ps
module adc_status_flags_test;
   import adc_flag_pkg::*;
   logic              clk, rst_n, rdy, err, start, sleep, irq, w;
   apb_req_s          req;
   conv_end_s         cv_in, c;
   logic [DATA_W-1:0] rdata, r;
   logic [NUM_CH-1:0] en, m_done, m_ovr, m_en;
   logic              m_data_ready_flag, m_govr, m_sleep;
   logic [CH_W-1:0]   m_lch;
   logic [RES_W-1:0]  m_ldat, m_res [NUM_CH];
   logic [EVT_W-1:0]  m_ist, m_msk;
   logic [ADDR_W-1:0] a;
   logic [ADDR_W-1:0] rd_tab [8] = '{OFS_STATUS, OFS_STATUS, OFS_LAST, OFS_LAST, OFS_CH_STAT, OFS_IRQ_STAT,
      OFS_IRQ_MASK, 8'h2C};
   logic [ADDR_W-1:0] wr_tab [4] = '{OFS_CH_EN, OFS_CH_DIS, OFS_IRQ_STAT, OFS_IRQ_MASK};
   int                err_total, n_checks, seed;

   adc_status_flags dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .APB_REQ_IN(req), .CONV_END_IN(cv_in),
      .PRDATA_OUT(rdata), .PREADY_OUT(rdy), .PSLVERR_OUT(err), .CH_EN_OUT(en), .START_OUT(start),
      .SLEEP_OUT(sleep), .IRQ_OUT(irq));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // -------------------------------------------------------------------
   // reference model, updated at the setup edge as the slave is
   // -------------------------------------------------------------------
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] ra(input int i);
      return OFS_RES_BASE + 8'(4 * i);
   endfunction

   function automatic logic isres(input logic [7:0] x);
      return x >= OFS_RES_BASE && x <= OFS_RES_TOP && x[1:0] == 2'h0;
   endfunction

   function automatic logic mapped(input logic [7:0] x);
      return isres(x) || x inside {OFS_CTRL, OFS_MODE, OFS_CH_EN, OFS_CH_DIS, OFS_CH_STAT, OFS_STATUS, OFS_LAST,
         OFS_IRQ_STAT, OFS_IRQ_MASK};
   endfunction

   function automatic logic [31:0] exp_rd(input logic [7:0] x);
      case (x)
         OFS_MODE:     return {26'h000_0000, m_sleep, 5'h00};
         OFS_CH_STAT:  return {24'h00_0000, m_en};
         OFS_STATUS:   return {14'h0000, m_govr, m_data_ready_flag, m_ovr, m_done};
         OFS_LAST:     return {17'h0_0000, m_lch, 2'h0, m_ldat};
         OFS_IRQ_STAT: return {30'h0000_0000, m_ist};
         OFS_IRQ_MASK: return {30'h0000_0000, m_msk};
         default:      return isres(x) ? {22'h00_0000, m_res[(x - OFS_RES_BASE) >> 2]} : DATA_ZERO;
      endcase
   endfunction

   function automatic conv_end_s mk(input logic v, input logic [2:0] ch);
      logic [31:0] rr;
      rr = $random(seed);
      return '{v, ch, rr[9:0]};
   endfunction

   // clears first, then sets from the flags as they stood before the edge
   task step(input logic wi, input logic [7:0] ai, input logic [31:0] d, input conv_end_s cv);
      logic st;
      logic was_done;
      logic was_rdy;
      st = cv.valid && m_en[cv.ch];
      was_done = m_done[cv.ch];
      was_rdy = m_data_ready_flag;
      if (!wi && ai == OFS_LAST) begin
         m_done[m_lch] = 1'b0;
         m_data_ready_flag = 1'b0;
      end
      if (!wi && isres(ai)) m_done[(ai - OFS_RES_BASE) >> 2] = 1'b0;
      if (!wi && ai == OFS_STATUS) begin
         m_ovr = '0;
         m_govr = 1'b0;
      end
      if (wi && ai == OFS_CH_EN) m_en = m_en | d[7:0];
      if (wi && ai == OFS_CH_DIS) m_en = m_en & ~d[7:0];
      if (wi && ai == OFS_IRQ_STAT) m_ist = m_ist & ~d[1:0];
      if (wi && ai == OFS_IRQ_MASK) m_msk = d[1:0];
      if (wi && ai == OFS_MODE) m_sleep = d[MODE_SLEEP_BIT];
      if (st) begin
         if (was_done) m_ovr[cv.ch] = 1'b1;
         if (was_rdy) m_ist[EVT_GOVR_BIT] = 1'b1;
         if (was_rdy) m_govr = 1'b1;
         m_done[cv.ch] = 1'b1;
         m_data_ready_flag = 1'b1;
         m_res[cv.ch] = cv.data;
         m_lch = cv.ch;
         m_ldat = cv.data;
         m_ist[EVT_STORE_BIT] = 1'b1;
      end
   endtask

   // one apb transfer, with an optional end of conversion in its setup cycle
   task xfer(input logic wi, input logic [7:0] ai, input logic [31:0] d, input conv_end_s cv);
      logic [31:0] ex;
      int n;
      ex = exp_rd(ai);
      n = 0;
      @(posedge clk);
      req <= '{1'b1, 1'b0, wi, ai, d};
      cv_in <= cv;
      @(posedge clk);
      step(wi, ai, d, cv);
      req.penable <= 1'b1;
      cv_in <= '0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      check({31'h0, rdy}, 32'h0000_0001);
      if (!wi) check(rdata, ex);
      check({31'h0, err}, {31'h0, !mapped(ai)});
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(negedge clk);
      check({31'h0, irq}, {31'h0, |(m_ist & m_msk)});
      check({24'h00_0000, en}, {24'h00_0000, m_en});
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // watchdog well beyond the expected run length
   initial begin
      #400_000;
      err_total++;
      give_verdict();
   end

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial begin
      seed = 32'h109e68ee;
      {rst_n, m_done, m_ovr, m_data_ready_flag, m_govr, m_sleep, m_lch, m_ldat, m_ist, m_msk} = '0;
      m_en = CH_EN_RST;
      foreach (m_res[i]) m_res[i] = RES_RST;
      req = '0;
      cv_in = '0;
      err_total = 0;
      n_checks = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rd_tab[i]) xfer(1'b0, rd_tab[i], 0, mk(0, 0));
      $display("test reset values done");
      xfer(1'b1, OFS_IRQ_MASK, 3, mk(0, 0));
      xfer(1'b1, OFS_CH_EN, 32'h0000_007F, mk(0, 0));
      xfer(1'b0, OFS_STATUS, 0, mk(1, 1));
      xfer(1'b1, OFS_CH_DIS, 32'h0000_0020, mk(1, 1));
      xfer(1'b0, OFS_STATUS, 0, mk(0, 0));
      xfer(1'b0, ra(3), 0, mk(1, 1));
      xfer(1'b0, ra(1), 0, mk(0, 0));
      xfer(1'b0, OFS_STATUS, 0, mk(1, 1));
      xfer(1'b0, OFS_LAST, 0, mk(1, 7));
      xfer(1'b0, OFS_STATUS, 0, mk(1, 4));
      xfer(1'b0, OFS_STATUS, 0, mk(0, 0));
      xfer(1'b1, OFS_CH_DIS, 32'h0000_0004, mk(0, 0));
      xfer(1'b0, ra(5), 0, mk(1, 2));
      xfer(1'b0, OFS_STATUS, 0, mk(1, 3));
      xfer(1'b0, ra(6), 0, mk(1, 4));
      xfer(1'b0, OFS_STATUS, 0, mk(0, 0));
      xfer(1'b0, 8'h08, 0, mk(0, 0));
      xfer(1'b1, 8'h2C, 32'hFFFF_FFFF, mk(0, 0));
      xfer(1'b1, OFS_IRQ_STAT, 3, mk(0, 0));
      $display("test coincident events done");
      xfer(1'b1, OFS_MODE, 32'h0000_0020, mk(0, 0));
      xfer(1'b1, OFS_CTRL, 32'h0000_0002, mk(0, 0));
      check({31'h0, sleep}, {31'h0, m_sleep});
      xfer(1'b0, OFS_MODE, 0, mk(0, 0));
      $display("test sleep then start done");
      // same-channel read and store together exercise the set-beats-clear ordering
      for (int i = 0; i < 300; i++) begin
         r = $random(seed);
         c = mk(r[0], r[3:1]);
         w = r[4] & r[5];
         a = w ? wr_tab[r[7:6]] : (r[11] ? ra(r[10:8]) : rd_tab[r[10:8]]);
         xfer(w, a, {24'h00_0000, r[31:24]}, c);
      end
      $display("test random traffic done");
      give_verdict();
   end
endmodule // adc_status_flags_test
